// [shared/serial_adc_defines.svh]
/*
 * constants of the serial converter control port: widths, channel codes,
 * test levels, output length codes and conversion timing.
 * assumes a 40 MHz system clock; included by bare name.
 */
`ifndef SERIAL_ADC_DEFINES_SVH
`define SERIAL_ADC_DEFINES_SVH

// ----------------------------------------
// widths and counts
// ----------------------------------------
`define ADC_RESULT_W      12
`define ADC_CMD_BITS      5'h08
`define ADC_ADDR_BITS     4'h4
`define ADC_SAMPLE_EDGE   5'h04

// ----------------------------------------
// channel codes and internal test levels
// ----------------------------------------
`define ADC_LAST_EXT_CH   4'hA
`define ADC_CH_TEST_MID   4'hB
`define ADC_CH_TEST_LOW   4'hC
`define ADC_CH_TEST_HIGH  4'hD
`define ADC_TEST_MID      12'h800
`define ADC_TEST_LOW      12'h000
`define ADC_TEST_HIGH     12'hFFF
`define ADC_BIPOLAR_FLIP  12'h800

// ----------------------------------------
// output length codes
// ----------------------------------------
`define ADC_LEN_12        2'h0
`define ADC_LEN_8         2'h1
`define ADC_LEN_16        2'h2

// ----------------------------------------
// timing
// ----------------------------------------
`define ADC_CONV_TIME_NS  10000
`define ADC_CLOCK_MHZ     40
`define ADC_CONV_CYCLES   ((`ADC_CONV_TIME_NS * `ADC_CLOCK_MHZ) / 1000)
`define ADC_STEP_CYCLES   (`ADC_CONV_CYCLES / `ADC_RESULT_W)

// ----------------------------------------
// reset values
// ----------------------------------------
`define ADC_DONE_RESET    1'b1

`endif

// [shared/serial_adc_pkg.sv]
/*
 * types of the serial converter control port.
 * assumes nothing beyond the defines header.
 */
package serial_adc_pkg;

    // synchronised pin levels, kept together
    typedef struct packed {
        logic select_n;
        logic shift_clock;
        logic command_data;
    } pins_s;

    // transfer port states
    typedef enum logic [2:0] {
        P_IDLE = 3'b001,
        P_XFER = 3'b010,
        P_DONE = 3'b100
    } port_state_e;

    // converter states
    typedef enum logic [1:0] {
        C_READY = 2'b01,
        C_CONV  = 2'b10
    } conv_state_e;

    typedef logic [11:0] sample_t;

endpackage : serial_adc_pkg

// [tb/host_serial_master.sv]
/* host serial port model: select, shift clock and command line.
   assumes shift period of 8 system clocks (200 ns at 40 MHz). */
`timescale 1ns/10ps
module host_serial_master (
    // clock
    input wire logic i_clock,
    // result pin
    input wire logic i_result_data,
    input wire logic i_result_oe,
    // host pins
    output logic     o_select_n,
    output logic     o_shift_clock,
    output logic     o_command_data
);
    // ----------------------------------------
    // idle pins
    // ----------------------------------------
    // shift clock stands low between frames
    initial begin
        o_select_n     = 1'b1;
        o_shift_clock  = 1'b0;
        o_command_data = 1'b0;
    end

    // ----------------------------------------
    // one frame of n shift clocks
    // ----------------------------------------
    // result sampled mid high phase, well clear of the falling-edge update
    task automatic xfer(input logic [7:0] cmd, input int n, output logic [15:0] got, output logic off);
        got = '0;
        off = 1'b0;
        @(posedge i_clock);
        o_select_n <= 1'b0;
        for (int i = 0; i < n; i++) begin
            o_command_data <= (i < 8) ? cmd[7 - i] : ~o_command_data;
            repeat (4) @(posedge i_clock);
            o_shift_clock <= 1'b1;
            repeat (2) @(posedge i_clock);
            got = {got[14:0], i_result_data};
            off = off | !i_result_oe;
            repeat (2) @(posedge i_clock);
            o_shift_clock <= 1'b0;
        end
        repeat (4) @(posedge i_clock);
        o_select_n     <= 1'b1;
        o_command_data <= ~o_command_data; // released line, no stale level
    endtask : xfer
endmodule : host_serial_master

// [tb/serial_adc_control_port_monitor.sv]
/* checker for the converter port: result pin, done and command timing.
   assumes a bind onto the port's top module and a single clock domain. */
`timescale 1ns/10ps
module serial_adc_control_port_monitor (
    // clock and reset
    input wire logic       i_clock,
    input wire logic       i_reset_n,
    // host pins
    input wire logic       i_select_n,
    input wire logic       i_shift_clock,
    // watched outputs
    input wire logic       o_result_data,
    input wire logic       o_result_oe,
    input wire logic       o_done,
    input wire logic [7:0] o_command
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_reset_n);

    // ----------------------------------------
    // edge ages
    // ----------------------------------------
    logic       sc_q;
    logic [3:0] fall_age;
    logic [3:0] rise_age;

    // raw pin ages; the design adds its own sync lag, hence the slack below
    always_ff @(posedge i_clock) begin
        sc_q     <= i_shift_clock;
        fall_age <= (!i_reset_n || (sc_q && !i_shift_clock)) ? 4'h0 : (&fall_age) ? 4'hF : fall_age + 4'h1;
        rise_age <= (!i_reset_n || (!sc_q && i_shift_clock)) ? 4'h0 : (&rise_age) ? 4'hF : rise_age + 4'h1;
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    AST_OE_ON: assert property ($fell(i_select_n) |-> ##[2:5] o_result_oe)
        else $error("result pin not enabled after select fall");
    AST_OE_OFF: assert property ($rose(i_select_n) |-> ##[2:5] !o_result_oe)
        else $error("result pin still driven after select rise");
    AST_DATA_QUIET: assert property (!o_result_oe |-> !o_result_data)
        else $error("result data active while released");
    AST_DATA_FALL: assert property (o_result_oe && $past(o_result_oe) && $changed(o_result_data)
        |-> fall_age <= 4'h7)
        else $error("result bit moved without a falling shift edge");
    AST_DONE_DROP: assert property ($fell(o_done) |-> fall_age <= 4'h7)
        else $error("done dropped away from a falling shift edge");
    AST_DONE_BOUND: assert property ($fell(o_done) |-> ##[1:400] o_done)
        else $error("conversion took longer than its limit");
    AST_DONE_HOLD: assert property ($fell(o_done) |-> !o_done [*8])
        else $error("done returned before conversion could run");
    AST_CMD_RISE: assert property ($changed(o_command) |-> rise_age <= 4'h7)
        else $error("command byte changed without a rising shift edge");
    AST_CMD_IDLE: assert property (i_select_n [*8] |=> $stable(o_command))
        else $error("command byte changed while deselected");

    // main scenarios reached
    cover property ($fell(o_done));
    cover property ($rose(o_done));
    cover property ($rose(o_result_oe));
endmodule : serial_adc_control_port_monitor

bind serial_adc_control_port serial_adc_control_port_monitor u_mon (
    .i_clock, .i_reset_n, .i_select_n, .i_shift_clock,
    .o_result_data, .o_result_oe, .o_done, .o_command
);

// [tb/serial_adc_control_port_tb.sv]
/* self-checking bench of the converter port: frames in seven formats, abort.
   assumes the host model and checker files compile before this one. */
`timescale 1ns/10ps
module serial_adc_control_port_tb;
    import serial_adc_pkg::*;

    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic              i_clock;
    logic              i_reset_n;
    logic              bip;
    logic              lsb;
    logic [1:0]        len;
    logic [10:0][11:0] ins;
    wire               sel_n;
    wire               sck;
    wire               sdi;
    logic              res;
    logic              oe;
    logic              done;
    logic [7:0]        cmd_o;
    logic [11:0]       prev;
    logic [15:0]       got;
    logic              off;
    logic [3:0]        chs [7];
    logic [3:0]        fmt [7];
    int                errors;
    int                checked;

    serial_adc_control_port DUT (
        .i_clock(i_clock), .i_reset_n(i_reset_n), .i_select_n(sel_n),
        .i_shift_clock(sck), .i_command_data(sdi), .i_analog_channel_inputs(ins),
        .i_bipolar(bip), .i_lsb_first(lsb), .i_out_length(len),
        .o_result_data(res), .o_result_oe(oe), .o_done(done), .o_command(cmd_o)
    );

    host_serial_master u_host (
        .i_clock(i_clock), .i_result_data(res), .i_result_oe(oe),
        .o_select_n(sel_n), .o_shift_clock(sck), .o_command_data(sdi)
    );

    // 40 MHz
    initial begin
        i_clock = 1'b0;
        forever #12.5 i_clock = ~i_clock;
    end

    // ----------------------------------------
    // compares and closing
    // ----------------------------------------
    task automatic end_sim;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_sim

    task automatic cmp16(input logic [15:0] g, input logic [15:0] e);
        checked++;
        if (g !== e) begin
            errors++;
            $display("BAD t=%0t got %h exp %h", $time, g, e);
        end
    endtask : cmp16

    task automatic cmp1(input logic g, input logic e);
        cmp16({15'h0000, g}, {15'h0000, e});
    endtask : cmp1

    // converted word expected for a channel code
    function automatic logic [11:0] chval(input logic [3:0] c);
        if (c <= 4'hA) return ins[c];
        if (c == 4'hB) return 12'h800;
        if (c == 4'hD) return 12'hFFF;
        return 12'h000;
    endfunction : chval

    // bounded wait; a hang counts as a mismatch
    task automatic wait_done;
        int n;
        n = 0;
        while (done !== 1'b1 && n < 400) begin
            @(posedge i_clock);
            n++;
        end
        cmp1(n < 400, 1'b1);
        if (n >= 400) end_sim();
    endtask : wait_done

    // one frame: format f = {bipolar, lsb first, length code}
    task automatic run(input logic [7:0] cmd, input logic [3:0] f);
        logic [15:0] e;
        logic [11:0] w;
        int          n;
        n = (f[1:0] == 2'h1) ? 8 : (f[1:0] == 2'h2) ? 16 : 12;
        w = prev ^ (f[3] ? 12'h800 : 12'h000);
        e = '0;
        for (int i = 0; i < n; i++) begin
            e = {e[14:0], (i < 12) ? w[f[2] ? i : 11 - i] : 1'b0};
        end
        @(posedge i_clock);
        bip <= f[3];
        lsb <= f[2];
        len <= f[1:0];
        u_host.xfer(cmd, n, got, off);
        cmp16(got, e);
        cmp1(off, 1'b0);
        cmp16({8'h00, cmd_o}, {8'h00, cmd});
        repeat (4) @(posedge i_clock);
        cmp1(done, 1'b0);
        wait_done();
        prev = chval(cmd[7:4]);
    endtask : run

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        errors    = 0;
        checked   = 0;
        i_reset_n = 1'b0;
        bip       = 1'b0;
        lsb       = 1'b0;
        len       = 2'h0;
        prev      = 12'h000;
        chs       = '{4'h3, 4'hB, 4'hC, 4'hD, 4'hE, 4'h0, 4'hA};
        fmt       = '{4'h0, 4'h4, 4'h8, 4'h1, 4'h6, 4'hC, 4'h3};
        for (int i = 0; i < 11; i++) begin
            ins[i] = 12'(12'h137 * (i + 1) + i);
        end
        repeat (12) @(posedge i_clock);
        i_reset_n <= 1'b1;
        @(posedge i_clock);
        cmp1(done, 1'b1);
        cmp1(oe, 1'b0);
        for (int k = 0; k < 7; k++) begin
            run({chs[k], ~chs[k]}, fmt[k]);
        end
        // short frame: select rises before the final edge, nothing converts
        u_host.xfer(8'h2D, 5, got, off);
        cmp16(got, {11'h000, prev[11:7]});
        repeat (8) @(posedge i_clock);
        cmp1(done, 1'b1);
        cmp16({8'h00, cmd_o}, 16'h00A5);
        run(8'h1E, 4'h0);
        end_sim();
    end
endmodule : serial_adc_control_port_tb

// [verilog/serial_adc_control_port.sv]
/*
 * serial control and result port of a 12-bit successive-approximation
 * converter with a 14-way input selector, modelled with digital samples.
 * assumes the host pins are asynchronous and slow against i_clock
 * (shift clock well under a quarter of the system rate); the analogue
 * inputs and format ports are steady words in the i_clock domain.
 */
`timescale 1ns/10ps
`include "serial_adc_defines.svh"

// Summary of operation
// - select falling resets counters, enables pins
// - select rising stops command and shift capture
// - four-bit address picks next conversion input
// - address msb first on first four rises
// - remaining command bits follow on later rises
// - result pin driven only while selected
// - first result bit appears at select fall
// - each falling edge advances result bit
// - done drops after final falling edge
// - done rises once new result ready
// - fourteen inputs: eleven external, three test
// - sampling happens automatically within transfer
// - conversion yields twelve-bit result
// - conversion completes within ten microseconds
// - unipolar or bipolar signed output format
// - host picks msb or lsb first
// - host picks result output length
// - eight command bits, address after fourth
// - sampling spans fourth to final falling edge
// - remaining bits change on falling edges only
// - final falling edge starts internal conversion
module serial_adc_control_port
    import serial_adc_pkg::*;
(
    // clock and reset
    input  wire logic                  i_clock,
    input  wire logic                  i_reset_n,
    // host pins
    input  wire logic                  i_select_n,
    input  wire logic                  i_shift_clock,
    input  wire logic                  i_command_data,
    // analogue inputs as sampled words
    input  wire logic [10:0][11:0]     i_analog_channel_inputs,
    // format choices
    input  wire logic                  i_bipolar,
    input  wire logic                  i_lsb_first,
    input  wire logic [1:0]            i_out_length,
    // result pin and status
    output logic                       o_result_data,
    output logic                       o_result_oe,
    output logic                       o_done,
    output logic [7:0]                 o_command
);

    // ----------------------------------------
    // helper functions
    // ----------------------------------------

    // input selector, unused codes read as the low test level
    function automatic sample_t select_input(input logic [3:0]       addr,
                                             input logic [10:0][11:0] ins);
        sample_t v;
        v = `ADC_TEST_LOW;
        if (addr <= `ADC_LAST_EXT_CH) begin
            v = ins[addr];
        end else if (addr == `ADC_CH_TEST_MID) begin
            v = `ADC_TEST_MID;
        end else if (addr == `ADC_CH_TEST_HIGH) begin
            v = `ADC_TEST_HIGH;
        end
        return v;
    endfunction : select_input

    // number of shift clocks for a length code
    function automatic logic [4:0] length_of(input logic [1:0] code);
        logic [4:0] n;
        n = 5'h0C;
        if (code == `ADC_LEN_8) begin
            n = 5'h08;
        end else if (code == `ADC_LEN_16) begin
            n = 5'h10;
        end
        return n;
    endfunction : length_of

    // result word placed at the top of the shifter
    function automatic logic [15:0] out_word(input sample_t res, input logic bip,
                                             input logic lsb);
        sample_t v;
        sample_t r;
        v = bip ? (res ^ `ADC_BIPOLAR_FLIP) : res;
        for (int k = 0; k < 12; k++) begin
            r[k] = v[11-k];
        end
        return {(lsb ? r : v), 4'h0};
    endfunction : out_word

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    pins_s sy1_r;
    pins_s sy2_r;
    pins_s sy3_r;

    // two flops per pin, a third copy only for edge finding
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            sy1_r <= '{select_n: 1'b1, shift_clock: 1'b0, command_data: 1'b0};
            sy2_r <= '{select_n: 1'b1, shift_clock: 1'b0, command_data: 1'b0};
            sy3_r <= '{select_n: 1'b1, shift_clock: 1'b0, command_data: 1'b0};
        end else begin
            sy1_r <= '{select_n: i_select_n, shift_clock: i_shift_clock,
                       command_data: i_command_data};
            sy2_r <= sy1_r;
            sy3_r <= sy2_r;
        end
    end

    logic sel_fall;
    logic sel_rise;
    logic clk_rise;
    logic clk_fall;

    // shift edges count only while selected
    assign sel_fall = sy3_r.select_n & ~sy2_r.select_n;
    assign sel_rise = ~sy3_r.select_n & sy2_r.select_n;
    assign clk_rise = ~sy2_r.select_n & ~sy3_r.shift_clock & sy2_r.shift_clock;
    assign clk_fall = ~sy2_r.select_n & sy3_r.shift_clock & ~sy2_r.shift_clock;

    // ----------------------------------------
    // transfer port
    // ----------------------------------------
    port_state_e pstate_r,  pstate_nxt;
    logic [4:0]  rise_r,    rise_nxt;
    logic [4:0]  fall_r,    fall_nxt;
    logic [4:0]  len_r,     len_nxt;
    logic [7:0]  cmd_r,     cmd_nxt;
    logic [7:0]  cmdo_r,    cmdo_nxt;
    logic [3:0]  chan_r,    chan_nxt;
    logic [15:0] out_r,     out_nxt;
    logic        oe_r,      oe_nxt;
    sample_t     held_r,    held_nxt;
    logic        start_r,   start_nxt;
    logic        data_r,    data_nxt;
    sample_t     result_r;

    // command capture, result shifting and sampling
    always_comb begin
        pstate_nxt = pstate_r;
        rise_nxt   = rise_r;
        fall_nxt   = fall_r;
        len_nxt    = len_r;
        cmd_nxt    = cmd_r;
        cmdo_nxt   = cmdo_r;
        chan_nxt   = chan_r;
        out_nxt    = out_r;
        oe_nxt     = oe_r;
        held_nxt   = held_r;
        start_nxt  = 1'b0;
        if (sel_fall) begin
            pstate_nxt = P_XFER;
            rise_nxt   = 5'h00;
            fall_nxt   = 5'h00;
            cmd_nxt    = 8'h00;
            oe_nxt     = 1'b1;
            len_nxt    = length_of(i_out_length);
            out_nxt    = out_word(result_r, i_bipolar, i_lsb_first);
        end else if (sel_rise) begin
            pstate_nxt = P_IDLE;
            oe_nxt     = 1'b0;
        end else if (pstate_r == P_XFER) begin
            // eight command bits, msb first
            if (clk_rise && rise_r < `ADC_CMD_BITS) begin
                cmd_nxt  = {cmd_r[6:0], sy2_r.command_data};
                rise_nxt = rise_r + 5'h01;
                if (rise_r == `ADC_CMD_BITS - 5'h01) begin
                    cmdo_nxt = {cmd_r[6:0], sy2_r.command_data};
                end
                if (rise_r == 5'({1'b0, `ADC_ADDR_BITS}) - 5'h01) begin
                    chan_nxt = {cmd_r[2:0], sy2_r.command_data};
                end
            end
            if (clk_fall) begin
                fall_nxt = fall_r + 5'h01;
                out_nxt  = {out_r[14:0], 1'b0};
                // sampling window: fourth to last falling edge
                if (fall_r + 5'h01 >= `ADC_SAMPLE_EDGE) begin
                    held_nxt = select_input(chan_r, i_analog_channel_inputs);
                end
                if (fall_r + 5'h01 == len_r) begin
                    pstate_nxt = P_DONE;
                    start_nxt  = 1'b1;
                end
            end
        end
        // pin level gets its own flop, held low whenever released
        data_nxt = out_nxt[15] & oe_nxt;
    end

    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            pstate_r <= P_IDLE;
            rise_r   <= 5'h00;
            fall_r   <= 5'h00;
            len_r    <= 5'h0C;
            cmd_r    <= 8'h00;
            cmdo_r   <= 8'h00;
            chan_r   <= 4'h0;
            out_r    <= 16'h0000;
            oe_r     <= 1'b0;
            held_r   <= 12'h000;
            start_r  <= 1'b0;
            data_r   <= 1'b0;
        end else begin
            pstate_r <= pstate_nxt;
            rise_r   <= rise_nxt;
            fall_r   <= fall_nxt;
            len_r    <= len_nxt;
            cmd_r    <= cmd_nxt;
            cmdo_r   <= cmdo_nxt;
            chan_r   <= chan_nxt;
            out_r    <= out_nxt;
            oe_r     <= oe_nxt;
            held_r   <= held_nxt;
            start_r  <= start_nxt;
            data_r   <= data_nxt;
        end
    end

    // ----------------------------------------
    // successive-approximation converter
    // ----------------------------------------
    conv_state_e cstate_r, cstate_nxt;
    sample_t     sar_r,    sar_nxt;
    logic [3:0]  bit_r,    bit_nxt;
    logic [5:0]  step_r,   step_nxt;
    sample_t     res_nxt;
    logic        done_r,   done_nxt;
    sample_t     trial;

    // one result bit per step; twelve steps fit inside the time limit
    always_comb begin
        cstate_nxt = cstate_r;
        sar_nxt    = sar_r;
        bit_nxt    = bit_r;
        step_nxt   = step_r;
        res_nxt    = result_r;
        done_nxt   = done_r;
        trial      = sar_r | (12'h001 << bit_r);
        unique case (cstate_r)
            C_READY: begin
                if (start_r) begin
                    cstate_nxt = C_CONV;
                    sar_nxt    = 12'h000;
                    bit_nxt    = 4'hB;
                    step_nxt   = 6'h00;
                    done_nxt   = 1'b0;
                end
            end
            C_CONV: begin
                step_nxt = step_r + 6'h01;
                if (step_r == 6'(`ADC_STEP_CYCLES - 1)) begin
                    step_nxt = 6'h00;
                    if (held_r >= trial) begin
                        sar_nxt = trial;
                    end
                    bit_nxt = bit_r - 4'h1;
                    if (bit_r == 4'h0) begin
                        cstate_nxt = C_READY;
                        res_nxt    = (held_r >= trial) ? trial : sar_r;
                        done_nxt   = 1'b1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            cstate_r <= C_READY;
            sar_r    <= 12'h000;
            bit_r    <= 4'h0;
            step_r   <= 6'h00;
            result_r <= 12'h000;
            done_r   <= `ADC_DONE_RESET;
        end else begin
            cstate_r <= cstate_nxt;
            sar_r    <= sar_nxt;
            bit_r    <= bit_nxt;
            step_r   <= step_nxt;
            result_r <= res_nxt;
            done_r   <= done_nxt;
        end
    end

    // ----------------------------------------
    // outputs, all straight from flops
    // ----------------------------------------
    assign o_result_data = data_r;             // low while released
    assign o_result_oe   = oe_r;
    assign o_done        = done_r;
    assign o_command     = cmdo_r;

endmodule : serial_adc_control_port
